// [fac_pkg.sv]
// fac_pkg: constants, register map and shared functions of the fault-alert
// and frame-check block.
// assumes a single pclk domain at 125 MHz; nothing outside this file is needed.

package fac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FAULT = 8'h04;
  localparam logic [7:0] REG_DAC = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_EN = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // control register fields
  localparam int CTRL_WDT_SEL_LSB = 0;
  localparam int CTRL_WDT_EN_BIT = 3;
  localparam int CTRL_AUTO_RB_BIT = 4;
  localparam logic [15:0] CTRL_RESET = 16'h0008;
  localparam logic [15:0] DAC_RESET = 16'h0000;

  // fault register bits
  localparam int FLT_PKT_ERR_BIT = 0;
  localparam int FLT_TMO_BIT = 1;
  localparam int FLT_LOW_BIT = 2;
  localparam int FLT_HIGH_BIT = 3;

  // interrupt status / enable / clear bits
  localparam int IRQ_W = 5;
  localparam int IRQ_PKT_ERR_BIT = 0;
  localparam int IRQ_TMO_BIT = 1;
  localparam int IRQ_LOW_BIT = 2;
  localparam int IRQ_HIGH_BIT = 3;
  localparam int IRQ_FRAME_BIT = 4;
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 5'h00;

  // status register fields
  localparam int STAT_ALARM_BIT = 16;
  localparam int STAT_RB_PEND_BIT = 17;

  ////////////////////////////////////////////////////////////////////////////
  // serial frame layout: bit 23 read, bits 22:16 address, bits 15:0 data
  localparam int FRAME_BITS_PLAIN = 24;
  localparam int FRAME_BITS_CHECKED = 32;
  localparam int FRAME_RD_BIT = 23;
  localparam logic [6:0] SADDR_DAC = 7'h01;
  localparam logic [6:0] SADDR_CTRL = 7'h02;
  localparam logic [6:0] SADDR_FAULT = 7'h05;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ = 125;
  localparam int WDT_TICK_MS = 1;
  localparam int WDT_TICK_CYCLES = WDT_TICK_MS * CLK_MHZ * 1000;
  localparam logic [12:0] WDT_MS_0 = 13'h0032;
  localparam logic [12:0] WDT_MS_1 = 13'h0064;
  localparam logic [12:0] WDT_MS_2 = 13'h01f4;
  localparam logic [12:0] WDT_MS_3 = 13'h03e8;
  localparam logic [12:0] WDT_MS_4 = 13'h07d0;
  localparam logic [12:0] WDT_MS_5 = 13'h0bb8;
  localparam logic [12:0] WDT_MS_6 = 13'h0fa0;
  localparam logic [12:0] WDT_MS_7 = 13'h1388;

  // loop current window: 0.01 % of a 16-bit full scale, rounded down
  localparam int LOOP_TOL_PPM = 100;
  localparam int LOOP_FS_CODES = 65536;
  localparam logic [16:0] LOOP_TOL_CODES = 17'((LOOP_FS_CODES * LOOP_TOL_PPM) / 1000000);
  localparam logic [15:0] ALARM_CODE_UP = 16'hffff;
  localparam logic [15:0] ALARM_CODE_DOWN = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // crc-8, msb first, zero start, over a 24-bit word
  function automatic logic [7:0] crc24(input logic [23:0] word);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      c = (c[7] ^ word[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [12:0] wdt_limit(input logic [2:0] sel);
    case (sel)
      3'h0: wdt_limit = WDT_MS_0;
      3'h1: wdt_limit = WDT_MS_1;
      3'h2: wdt_limit = WDT_MS_2;
      3'h3: wdt_limit = WDT_MS_3;
      3'h4: wdt_limit = WDT_MS_4;
      3'h5: wdt_limit = WDT_MS_5;
      3'h6: wdt_limit = WDT_MS_6;
      default: wdt_limit = WDT_MS_7;
    endcase
  endfunction

endpackage

// [fac_sync.sv]
// fac_sync: two-flop synchroniser for a bundle of pins.
// assumes the inputs are independent levels; multi-bit words must not pass here.
`timescale 1ns/1ps
`default_nettype none

module fac_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } fac_sync_s;

  fac_sync_s s_r;
  fac_sync_s s_nxt;

  // first stage feeds only the second stage
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = d;
    s_nxt.q = s_r.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;

endmodule

`default_nettype wire

// [fac_top.sv]
// fac_top: serial watchdog, frame check on write and readback frames,
// loop current window flags, fault pin and interrupt, apb register slave.
// assumes a host on a three-wire serial link clocked slower than pclk/4,
// and a measured loop code from logic on pclk.
//
// Overview of operation
// - every fault drives pin and fault register
// - watchdog times out after selected idle period
// - timeout forces loop current to alarm
// - alarm active: watchdog does not restart
// - expired watchdog waits for status readback
// - polarity pin selects upscale or downscale alarm
// - 32-bit write frame carries check byte
// - check byte is crc-8, x^8+x^2+x+1
// - bad check: drop write, flag, alert
// - fault read clears packet error, pin
// - readback appends crc over 24 data bits
// - loop deviation sets low or high flag
// - loop low or high drives fault pin
`timescale 1ns/1ps
`default_nettype none

module fac_top #(
  parameter int unsigned TICK_CYCLES = fac_pkg::WDT_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  output logic sdout,
  output logic sdout_oe,
  input wire logic alarm_dir,
  input wire logic [15:0] loop_meas,
  output logic fault_pin,
  output logic irq,
  output logic [15:0] loop_code,
  output logic loop_alarm,
  output logic alarm_upscale
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] dac;
    logic pkt_err;
    logic tmo;
    logic lo;
    logic hi;
    logic [fac_pkg::IRQ_W-1:0] irq_stat;
    logic [fac_pkg::IRQ_W-1:0] irq_en;
    logic irq;
    logic [16:0] tick_cnt;
    logic [12:0] wd_cnt;
    logic wd_exp;
    logic sclk_q;
    logic sync_q;
    logic [31:0] rx_sh;
    logic [5:0] rx_cnt;
    logic [31:0] tx_sh;
    logic rb_pend;
    logic [6:0] rb_addr;
    logic sdout;
    logic sdout_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fault;
    logic [15:0] loop_code;
    logic alarm;
    logic up;
  } fac_state_s;

  localparam fac_state_s RESET_S = '{
    ctrl: fac_pkg::CTRL_RESET, dac: fac_pkg::DAC_RESET, irq_en: fac_pkg::IRQ_EN_RESET,
    sclk_q: 1'b0, sync_q: 1'b0, loop_code: fac_pkg::ALARM_CODE_DOWN, default: '0}; // match synchroniser reset

  fac_state_s s_r;
  fac_state_s s_nxt;

  logic sclk_s;
  logic sync_s;
  logic sdin_s;
  logic dir_s;

  localparam int IRQ_W_L = fac_pkg::IRQ_W;

  ////////////////////////////////////////////////////////////////////////////
  // pins from outside the pclk domain
  fac_sync #(.W(4)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({sclk, sync_n, sdin, alarm_dir}),
    .q({sclk_s, sync_s, sdin_s, dir_s})
  );

  function automatic logic [15:0] fault_word(input fac_state_s st);
    fault_word = '0;
    fault_word[fac_pkg::FLT_PKT_ERR_BIT] = st.pkt_err;
    fault_word[fac_pkg::FLT_TMO_BIT] = st.tmo;
    fault_word[fac_pkg::FLT_LOW_BIT] = st.lo;
    fault_word[fac_pkg::FLT_HIGH_BIT] = st.hi;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic sclk_rise;
    logic sclk_fall;
    logic sync_fall;
    logic sync_rise;
    logic apb_acc;
    logic status_rd;
    logic frm_valid;
    logic pkt_err_set;
    logic tmo_set;
    logic tick;
    logic [23:0] word;
    logic [23:0] tx_word;
    logic [6:0] tx_addr;
    logic tx_have;
    logic [15:0] tx_data;
    logic [IRQ_W_L-1:0] irq_ev;
    logic [IRQ_W_L-1:0] irq_clr;
    logic [16:0] meas;
    logic [16:0] tgt;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    sync_fall = 1'b0;
    sync_rise = 1'b0;
    apb_acc = 1'b0;
    status_rd = 1'b0;
    frm_valid = 1'b0;
    pkt_err_set = 1'b0;
    tmo_set = 1'b0;
    tick = 1'b0;
    word = '0;
    tx_word = '0;
    tx_addr = '0;
    tx_have = 1'b0;
    tx_data = '0;
    irq_ev = '0;
    irq_clr = '0;
    meas = {1'b0, loop_meas};
    tgt = {1'b0, s_r.loop_code};
    s_nxt = s_r;

    // edge detection on synchronised pins
    sclk_rise = sclk_s & ~s_r.sclk_q;
    sclk_fall = ~sclk_s & s_r.sclk_q;
    sync_fall = ~sync_s & s_r.sync_q;
    sync_rise = sync_s & ~s_r.sync_q;
    s_nxt.sclk_q = sclk_s;
    s_nxt.sync_q = sync_s;

    // apb: zero wait states, read data and error staged in the setup cycle
    s_nxt.pready = 1'b1;
    apb_acc = psel & penable & s_r.pready;
    if (psel & ~penable) begin
      s_nxt.pslverr = 1'b0;
      case (paddr)
        fac_pkg::REG_CTRL: s_nxt.prdata = {16'h0000, s_r.ctrl};
        fac_pkg::REG_FAULT: s_nxt.prdata = {16'h0000, fault_word(s_r)};
        fac_pkg::REG_DAC: s_nxt.prdata = {16'h0000, s_r.dac};
        fac_pkg::REG_IRQ_STAT: s_nxt.prdata = {27'h0000000, s_r.irq_stat};
        fac_pkg::REG_IRQ_EN: s_nxt.prdata = {27'h0000000, s_r.irq_en};
        fac_pkg::REG_IRQ_CLR: s_nxt.prdata = 32'h00000000;
        fac_pkg::REG_STATUS: s_nxt.prdata = {14'h0000, s_r.rb_pend, s_r.wd_exp, 3'h0, s_r.wd_cnt};
        default: begin
          s_nxt.prdata = 32'h00000000;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_acc & pwrite) begin
      case (paddr)
        fac_pkg::REG_CTRL: s_nxt.ctrl = pwdata[15:0];
        fac_pkg::REG_DAC: s_nxt.dac = pwdata[15:0];
        fac_pkg::REG_IRQ_EN: s_nxt.irq_en = pwdata[IRQ_W_L-1:0];
        fac_pkg::REG_IRQ_CLR: irq_clr = pwdata[IRQ_W_L-1:0];
        default: s_nxt.ctrl = s_nxt.ctrl;
      endcase
    end
    if (apb_acc & ~pwrite & (paddr == fac_pkg::REG_FAULT)) begin
      status_rd = 1'b1;
    end

    // serial receive: sample on sclk rise while the frame is selected
    if (sync_fall) begin
      s_nxt.rx_cnt = '0;
    end else if (sclk_rise & ~sync_s) begin
      s_nxt.rx_sh = {s_r.rx_sh[30:0], sdin_s};
      if (s_r.rx_cnt != 6'h3f) begin
        s_nxt.rx_cnt = s_r.rx_cnt + 6'h01;
      end
    end

    // frame end: 32 bits carry a check byte, 24 bits do not, others dropped
    if (sync_rise) begin
      if (s_r.rx_cnt == 6'(fac_pkg::FRAME_BITS_CHECKED)) begin
        word = s_r.rx_sh[31:8];
        if (fac_pkg::crc24(word) == s_r.rx_sh[7:0]) begin
          frm_valid = 1'b1;
        end else begin
          pkt_err_set = 1'b1;
        end
      end else if (s_r.rx_cnt == 6'(fac_pkg::FRAME_BITS_PLAIN)) begin
        word = s_r.rx_sh[23:0];
        frm_valid = 1'b1;
      end
    end
    // a failed frame never touches dac, control or readback state
    if (frm_valid) begin
      if (word[fac_pkg::FRAME_RD_BIT]) begin
        s_nxt.rb_pend = 1'b1;
        s_nxt.rb_addr = word[22:16];
      end else if (word[22:16] == fac_pkg::SADDR_DAC) begin
        s_nxt.dac = word[15:0];
      end else if (word[22:16] == fac_pkg::SADDR_CTRL) begin
        s_nxt.ctrl = word[15:0];
      end
    end

    // serial transmit: pending readback, else the fault register when auto
    // readback is on; the crc is always appended, a 24-clock host ignores it
    if (sync_fall) begin
      if (s_r.rb_pend) begin
        tx_have = 1'b1;
        tx_addr = s_r.rb_addr;
      end else if (s_r.ctrl[fac_pkg::CTRL_AUTO_RB_BIT]) begin
        tx_have = 1'b1;
        tx_addr = fac_pkg::SADDR_FAULT;
      end
      case (tx_addr)
        fac_pkg::SADDR_DAC: tx_data = s_r.dac;
        fac_pkg::SADDR_CTRL: tx_data = s_r.ctrl;
        fac_pkg::SADDR_FAULT: tx_data = fault_word(s_r);
        default: tx_data = 16'h0000;
      endcase
      tx_word = tx_have ? {1'b0, tx_addr, tx_data} : 24'h000000;
      if (tx_have & (tx_addr == fac_pkg::SADDR_FAULT)) begin
        status_rd = 1'b1;
      end
      s_nxt.rb_pend = 1'b0;
      s_nxt.tx_sh = {tx_word, fac_pkg::crc24(tx_word)};
      s_nxt.sdout = tx_word[23];
      s_nxt.sdout_oe = 1'b1;
    end else if (sync_rise) begin
      s_nxt.sdout = 1'b0;
      s_nxt.sdout_oe = 1'b0;
    end else if (sclk_fall & ~sync_s) begin
      s_nxt.tx_sh = {s_r.tx_sh[30:0], 1'b0};
      s_nxt.sdout = s_r.tx_sh[30];
    end

    // watchdog: millisecond tick from the pclk divider
    if (s_r.tick_cnt == 17'(TICK_CYCLES - 1)) begin
      tick = 1'b1;
      s_nxt.tick_cnt = '0;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 17'h00001;
    end
    if (!s_r.ctrl[fac_pkg::CTRL_WDT_EN_BIT]) begin
      s_nxt.wd_cnt = '0;
      s_nxt.wd_exp = 1'b0;
    end else if (s_r.wd_exp) begin
      // frozen while in alarm; only a status readback or clearing the enable bit releases it
      if (status_rd) begin
        s_nxt.wd_exp = 1'b0;
        s_nxt.wd_cnt = '0;
      end
    end else if (frm_valid) begin
      s_nxt.wd_cnt = '0;
    end else if (tick) begin
      if (s_r.wd_cnt + 13'h0001 >= fac_pkg::wdt_limit(s_r.ctrl[fac_pkg::CTRL_WDT_SEL_LSB +: 3])) begin
        s_nxt.wd_exp = 1'b1;
        tmo_set = 1'b1;
      end else begin
        s_nxt.wd_cnt = s_r.wd_cnt + 13'h0001;
      end
    end

    // sticky fault flags: a new event wins over a same-cycle read
    s_nxt.pkt_err = (status_rd ? 1'b0 : s_r.pkt_err) | pkt_err_set;
    s_nxt.tmo = (status_rd ? 1'b0 : s_r.tmo) | tmo_set;

    // alarm level chosen by the polarity pin
    s_nxt.up = dir_s;
    s_nxt.alarm = s_nxt.wd_exp;
    if (s_nxt.wd_exp) begin
      s_nxt.loop_code = dir_s ? fac_pkg::ALARM_CODE_UP : fac_pkg::ALARM_CODE_DOWN;
    end else begin
      s_nxt.loop_code = s_nxt.dac;
    end

    // loop window against the code now driven
    s_nxt.lo = (meas + fac_pkg::LOOP_TOL_CODES) < tgt;
    s_nxt.hi = meas > (tgt + fac_pkg::LOOP_TOL_CODES);
    s_nxt.fault = s_nxt.pkt_err | s_nxt.tmo | s_nxt.lo | s_nxt.hi;

    // interrupt status: set wins over clear
    irq_ev[fac_pkg::IRQ_PKT_ERR_BIT] = pkt_err_set;
    irq_ev[fac_pkg::IRQ_TMO_BIT] = tmo_set;
    irq_ev[fac_pkg::IRQ_LOW_BIT] = s_nxt.lo & ~s_r.lo;
    irq_ev[fac_pkg::IRQ_HIGH_BIT] = s_nxt.hi & ~s_r.hi;
    irq_ev[fac_pkg::IRQ_FRAME_BIT] = frm_valid;
    s_nxt.irq_stat = (s_r.irq_stat & ~irq_clr) | irq_ev;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= RESET_S;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign sdout = s_r.sdout;
  assign sdout_oe = s_r.sdout_oe;
  assign fault_pin = s_r.fault;
  assign irq = s_r.irq;
  assign loop_code = s_r.loop_code;
  assign loop_alarm = s_r.alarm;
  assign alarm_upscale = s_r.up;

endmodule

`default_nettype wire

// [fac_sva.sv]
// fac_sva: port-level checks of the fault-alert and frame-check block.
// assumes one pclk domain; bound onto fac_top from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module fac_sva #(
  parameter int unsigned TICK_CYCLES = fac_pkg::WDT_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic sync_n,
  input wire logic sdout_oe,
  input wire logic alarm_dir,
  input wire logic [15:0] loop_meas,
  input wire logic fault_pin,
  input wire logic [15:0] loop_code,
  input wire logic loop_alarm,
  input wire logic alarm_upscale
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  wire logic acc = psel && penable;
  wire logic fread = acc && !pwrite && paddr == fac_pkg::REG_FAULT;
  // window of 6 codes either way
  wire logic lo = ({1'b0, loop_meas} + 17'd6) < {1'b0, loop_code};
  wire logic hi = ({1'b0, loop_code} + 17'd6) < {1'b0, loop_meas};
  wire logic lok = !lo && !hi;
  ////////////////////////////////////////////////////////////////////////////
  a_loop_low: assert property (lo [*3] |-> fault_pin)
    else $error("loop below target without fault pin");
  a_loop_high: assert property (hi [*3] |-> fault_pin)
    else $error("loop above target without fault pin");
  a_alarm_code: assert property (loop_alarm [*3] |-> loop_code == (alarm_upscale ? 16'hffff : 16'h0000))
    else $error("alarm code wrong");
  a_pol_follow: assert property ($changed(alarm_dir) |-> ##[2:5] alarm_upscale == alarm_dir)
    else $error("polarity not followed");
  // frame effects land a few cycles after select rises, so wait them out
  a_alarm_hold: assert property (sync_n [*6] ##0 (loop_alarm && !acc) |=> loop_alarm)
    else $error("alarm dropped without readback");
  a_fault_clear: assert property ((fread && sync_n && !loop_alarm && lok) ##1 lok |=> !fault_pin)
    else $error("fault pin kept after fault read");
  a_oe_frame: assert property (!sync_n [*6] |-> sdout_oe)
    else $error("readback not driven in frame");
  a_oe_idle: assert property (sync_n [*6] |-> !sdout_oe)
    else $error("readback driven outside frame");
endmodule
`default_nettype wire

// [fac_host.sv]
// fac_host: behavioural host on the three-wire link, 80 ns serial clock.
// assumes the device samples on sclk rise; clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module fac_host (
  output logic sclk,
  output logic sync_n,
  output logic sdin,
  input wire logic sdout
);
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdin = 1'b1;
  end
  function automatic logic [7:0] crc8(input logic [23:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic frame(input logic [31:0] w, input int n, output logic [31:0] r);
    r = 32'h0;
    // start off the pclk edge so no pin change races the synchronisers
    #2 sync_n = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      sdin = w[i];
      #40 sclk = 1'b1;
      r = {r[30:0], sdout};
      #40 sclk = 1'b0;
    end
    #40 sync_n = 1'b1;
    // released line shows the inverse so a stale bit is never read as data
    sdin = ~sdin;
    #64;
  endtask
endmodule
`default_nettype wire

// [fac_top_tb_top.sv]
// fac_top_tb_top: directed bench with apb master and loop sensor stand-in.
// assumes fac_host on the link and a short watchdog tick of 10 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %h got %h", nm, e, a); end end
module fac_top_tb_top;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, alarm_dir, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, rx;
  logic [15:0] loop_meas, off;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, sclk, sync_n, sdin, sdout, sdout_oe, fault_pin, irq, loop_alarm, alarm_upscale;
  wire logic [15:0] loop_code;
  int n_mismatch = 0;
  int checked = 0;
  always #4 pclk = ~pclk;
  // sensor follows the driven code with a chosen error
  always @(posedge pclk) loop_meas <= loop_code + off;
  fac_top #(.TICK_CYCLES(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sclk, .sync_n, .sdin, .sdout, .sdout_oe, .alarm_dir, .loop_meas, .fault_pin,
    .irq, .loop_code, .loop_alarm, .alarm_upscale);
  fac_host host (.sclk, .sync_n, .sdin, .sdout);
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin n_mismatch++; close_out(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] wf(input logic [23:0] x);
    return {x, host.crc8(x)};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK("loop_code", 16'h0000, loop_code)
    apb(1'b0, fac_pkg::REG_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000008, rd)
    apb(1'b0, fac_pkg::REG_IRQ_EN, 32'h0);
    `CHK("irq_en", 32'h00000000, rd)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, fac_pkg::REG_CTRL, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_check();
    apb(1'b1, fac_pkg::REG_IRQ_EN, 32'h1);
    host.frame(wf({1'b0, fac_pkg::SADDR_DAC, 16'h1234}), 32, rx);
    cyc(8);
    `CHK("dac", 16'h1234, loop_code)
    host.frame(wf({1'b0, fac_pkg::SADDR_DAC, 16'h5678}) ^ 32'h1, 32, rx);
    cyc(8);
    `CHK("dac_kept", 16'h1234, loop_code)
    `CHK("pin", 1'b1, fault_pin)
    `CHK("irq", 1'b1, irq)
    apb(1'b0, fac_pkg::REG_FAULT, 32'h0);
    `CHK("pkt_err", 1'b1, rd[0])
    cyc(2);
    `CHK("pin_clr", 1'b0, fault_pin)
    apb(1'b0, fac_pkg::REG_FAULT, 32'h0);
    `CHK("pkt_err_clr", 1'b0, rd[0])
    apb(1'b1, fac_pkg::REG_IRQ_CLR, 32'h1);
    cyc(1);
    `CHK("irq_clr", 1'b0, irq)
    $display("t_check done");
  endtask
  task automatic t_readback();
    host.frame(wf({1'b1, fac_pkg::SADDR_DAC, 16'h0000}), 32, rx);
    cyc(8);
    host.frame(wf({1'b0, fac_pkg::SADDR_DAC, 16'h1234}), 32, rx);
    cyc(8);
    `CHK("readback", {24'h011234, host.crc8(24'h011234)}, rx)
    host.frame({8'h0, 1'b0, fac_pkg::SADDR_DAC, 16'h2222}, 24, rx);
    cyc(8);
    `CHK("plain", 16'h2222, loop_code)
    $display("t_readback done");
  endtask
  task automatic t_loop();
    logic [15:0] offs [3] = '{16'hfff9, 16'h0007, 16'hfffa};
    logic [3:0] flt [3] = '{4'h4, 4'h8, 4'h0};
    for (int k = 0; k < 3; k++) begin
      off <= offs[k];
      cyc(6);
      apb(1'b0, fac_pkg::REG_FAULT, 32'h0);
      `CHK("loop_flags", flt[k], rd[3:0])
      `CHK("loop_pin", |flt[k], fault_pin)
    end
    off <= 16'h0000;
    cyc(4);
    $display("t_loop done");
  endtask
  task automatic t_wdt();
    for (int d = 1; d >= 0; d--) begin
      alarm_dir <= d[0];
      apb(1'b1, fac_pkg::REG_CTRL, 32'h8);
      for (int i = 0; i < 2000 && loop_alarm !== 1'b1; i++) @(posedge pclk);
      if (loop_alarm !== 1'b1) begin n_mismatch++; close_out(); end
      cyc(2);
      `CHK("alarm_code", d[0] ? 16'hffff : 16'h0000, loop_code)
      `CHK("tmo_pin", 1'b1, fault_pin)
      host.frame(wf({1'b0, fac_pkg::SADDR_DAC, 16'h3333}), 32, rx);
      cyc(8);
      `CHK("held", 1'b1, loop_alarm)
      apb(1'b0, fac_pkg::REG_FAULT, 32'h0);
      `CHK("tmo", 1'b1, rd[1])
      cyc(2);
      `CHK("rearm", 1'b0, loop_alarm)
    end
    // valid frame restarts the count, a failed one does not
    cyc(100);
    host.frame(wf({1'b0, fac_pkg::SADDR_DAC, 16'h4444}), 32, rx);
    cyc(300);
    `CHK("restart", 1'b0, loop_alarm)
    host.frame(wf({1'b0, fac_pkg::SADDR_DAC, 16'h4444}) ^ 32'h1, 32, rx);
    `CHK("no_restart", 1'b1, loop_alarm)
    cyc(1);
    apb(1'b0, fac_pkg::REG_FAULT, 32'h0);
    apb(1'b1, fac_pkg::REG_CTRL, 32'h0);
    $display("t_wdt done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    alarm_dir = 1'b1;
    off = 16'h0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    t_reset();
    t_check();
    t_readback();
    t_loop();
    t_wdt();
    close_out();
  end
endmodule
bind fac_top fac_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .sync_n, .sdout_oe, .alarm_dir, .loop_meas, .fault_pin, .loop_code, .loop_alarm, .alarm_upscale);
`default_nettype wire
